// [include/dacsp_pkg.sv]
package dacsp_pkg;

  // word lengths and counters
  localparam int unsigned CNT_W = 16;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CH_N = 16;
  localparam logic [15:0] LEN_SHORT = 16'h0018;
  localparam logic [15:0] LEN_LONG = 16'h0020;

  typedef logic [7:0] dacsp_byte_t;
  typedef logic [15:0] dacsp_half_t;

  // upper nibble of the command byte
  localparam logic [3:0] OP_CODE_WR = 4'h0;
  localparam logic [3:0] OP_SPAN_WR = 4'h1;
  localparam logic [3:0] OP_OFS_WR = 4'h2;
  localparam logic [3:0] OP_GAIN_WR = 4'h3;
  localparam logic [3:0] OP_CODE_UPD = 4'h4;
  localparam logic [3:0] OP_CODE_UPD_ALL = 4'h5;
  localparam logic [3:0] OP_GLOBAL_WR = 4'h7;
  localparam logic [3:0] OP_CODE_RD = 4'h8;
  localparam logic [3:0] OP_SPAN_RD = 4'h9;
  localparam logic [3:0] OP_OFS_RD = 4'hA;
  localparam logic [3:0] OP_GAIN_RD = 4'hB;

  // whole command bytes
  localparam logic [7:0] CMD_CFG_WR = 8'h70;
  localparam logic [7:0] CMD_FAULT_WR = 8'h76;
  localparam logic [7:0] CMD_ALL_CODE = 8'h78;
  localparam logic [7:0] CMD_ALL_CODE_UPD = 8'h79;
  localparam logic [7:0] CMD_ALL_SPAN = 8'h7A;
  localparam logic [7:0] CMD_ALL_SPAN_UPD = 8'h7B;
  localparam logic [7:0] CMD_CFG_RD = 8'hF0;
  localparam logic [7:0] CMD_FAULT_RD = 8'hF6;

  // reset values; span code 0 selects the 0 V to 5 V range
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] SPAN_RST = 16'h0000;
  localparam logic [15:0] OFS_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] FAULT_RST = 8'h00;

  // field positions
  localparam int unsigned CFG_CRC_EN_BIT = 0;
  localparam int unsigned FAULT_CNT_BIT = 0;
  localparam int unsigned FAULT_CRC_BIT = 1;

  // check code
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_INIT = 6'h00;

endpackage

// [logic/dacsp_port.sv]
`timescale 1ns/1ps
module dacsp_port
  import dacsp_pkg::*;
(
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic link_sclk,
  input wire logic select_and_load_n,
  input wire logic sdi,
  output logic sdo,
  // open-drain error pin
  output logic fault_o,
  output logic fault_oe_n,
  // executed command
  output logic cmd_valid,
  output dacsp_pkg::dacsp_byte_t cmd_code,
  output logic [3:0] cmd_chan,
  output dacsp_pkg::dacsp_half_t cmd_data
);

  typedef struct packed {
    logic [WORD_W-1:0] sh;
    logic [CNT_W-1:0] cnt;
  } dacsp_link_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic cs_f;
    logic [2:0] sck_sync;
    logic sck_f;
    logic [CNT_W-1:0] base;
    logic [WORD_W-1:0] tx;
    logic sdo;
    logic fault_o;
    logic fault_oe_n;
    logic [7:0] cfg;
    logic [7:0] fault_reg;
    logic [CH_N-1:0][15:0] code;
    logic [CH_N-1:0][15:0] span;
    logic [CH_N-1:0][15:0] ofs;
    logic [CH_N-1:0][15:0] gain;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [3:0] cmd_chan;
    logic [15:0] cmd_data;
  } dacsp_core_t;

  localparam dacsp_core_t CORE_RST = '{
    cs_sync: 3'h7,
    cs_f: 1'b1,
    fault_oe_n: 1'b1,
    cfg: CFG_RST,
    fault_reg: FAULT_RST,
    code: {CH_N{CODE_RST}},
    span: {CH_N{SPAN_RST}},
    ofs: {CH_N{OFS_RST}},
    gain: {CH_N{GAIN_RST}},
    default: '0
  };

  dacsp_link_t link_reg;
  dacsp_link_t link_next;
  dacsp_core_t core_reg;
  dacsp_core_t core_next;

  function automatic logic [5:0] crc6(input logic [23:0] d);
    logic [5:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic crc_skip(input logic [7:0] c);
    return (c == CMD_CFG_WR) || (c == CMD_FAULT_WR) ||
           (c == CMD_CFG_RD) || (c == CMD_FAULT_RD);
  endfunction

  // link side: shift in on rising serial clock
  always_comb begin
    link_next = link_reg;
    if (!select_and_load_n) begin
      link_next.sh = {link_reg.sh[WORD_W-2:0], sdi};
      link_next.cnt = link_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // core side
  always_comb begin
    logic cs_rise;
    logic sck_fall;
    logic [CNT_W-1:0] len;
    logic is24;
    logic is32;
    logic [WORD_W-1:0] word;
    logic [7:0] cmd;
    logic [3:0] ch;
    logic [15:0] data;
    logic [15:0] rd;
    logic crc_bad;
    cs_rise = 1'b0;
    sck_fall = 1'b0;
    len = '0;
    is24 = 1'b0;
    is32 = 1'b0;
    word = '0;
    cmd = '0;
    ch = '0;
    data = '0;
    rd = '0;
    crc_bad = 1'b0;
    core_next = core_reg;
    core_next.cmd_valid = 1'b0;
    core_next.cs_sync = {core_reg.cs_sync[1:0], select_and_load_n};
    core_next.sck_sync = {core_reg.sck_sync[1:0], link_sclk};
    if (core_reg.cs_sync[2] == core_reg.cs_sync[1]) begin
      core_next.cs_f = core_reg.cs_sync[2];
    end
    if (core_reg.sck_sync[2] == core_reg.sck_sync[1]) begin
      core_next.sck_f = core_reg.sck_sync[2];
    end
    cs_rise = (core_reg.cs_sync[2] == core_reg.cs_sync[1]) && core_reg.cs_sync[2] &&
              !core_reg.cs_f;
    sck_fall = (core_reg.sck_sync[2] == core_reg.sck_sync[1]) && !core_reg.sck_sync[2] &&
               core_reg.sck_f && !core_reg.cs_f;
    // reply shifts on falling serial clock
    if (sck_fall) begin
      core_next.tx = {core_reg.tx[WORD_W-2:0], 1'b0};
      core_next.sdo = core_reg.tx[WORD_W-2];
    end
    // link is idle while select is high, so its state is stable here
    if (cs_rise) begin
      len = link_reg.cnt - core_reg.base;
      core_next.base = link_reg.cnt;
      word = link_reg.sh;
      is24 = (len == LEN_SHORT);
      is32 = (len == LEN_LONG);
      core_next.fault_oe_n = 1'b1;
      core_next.tx = '0;
      if (!(is24 || is32)) begin
        core_next.fault_oe_n = 1'b0;
        core_next.fault_reg[FAULT_CNT_BIT] = 1'b1;
      end else begin
        cmd = is32 ? word[31:24] : word[23:16];
        data = is32 ? word[23:8] : word[15:0];
        ch = cmd[3:0];
        crc_bad = is32 && core_reg.cfg[CFG_CRC_EN_BIT] && !crc_skip(cmd) &&
                  (crc6(word[31:8]) != word[5:0]);
        if (crc_bad) begin
          core_next.fault_oe_n = 1'b0;
          core_next.fault_reg[FAULT_CRC_BIT] = 1'b1;
        end else begin
          core_next.cmd_valid = 1'b1;
          core_next.cmd_code = cmd;
          core_next.cmd_chan = ch;
          core_next.cmd_data = data;
          case (cmd[7:4])
            OP_CODE_WR, OP_CODE_UPD, OP_CODE_UPD_ALL: begin
              core_next.code[ch] = data;
            end
            OP_SPAN_WR: begin
              core_next.span[ch] = data;
            end
            OP_OFS_WR: begin
              core_next.ofs[ch] = data;
            end
            OP_GAIN_WR: begin
              core_next.gain[ch] = data;
            end
            OP_GLOBAL_WR: begin
              if (cmd == CMD_CFG_WR) begin
                core_next.cfg = data[7:0];
              end else if (cmd == CMD_FAULT_WR) begin
                core_next.fault_reg = data[7:0];
              end else if ((cmd == CMD_ALL_CODE) || (cmd == CMD_ALL_CODE_UPD)) begin
                core_next.code = {CH_N{data}};
              end else if ((cmd == CMD_ALL_SPAN) || (cmd == CMD_ALL_SPAN_UPD)) begin
                core_next.span = {CH_N{data}};
              end
            end
            OP_CODE_RD: begin
              rd = core_reg.code[ch];
            end
            OP_SPAN_RD: begin
              rd = core_reg.span[ch];
            end
            OP_OFS_RD: begin
              rd = core_reg.ofs[ch];
            end
            OP_GAIN_RD: begin
              rd = core_reg.gain[ch];
            end
            default: begin
              if (cmd == CMD_CFG_RD) begin
                rd = {8'h00, core_reg.cfg};
              end else if (cmd == CMD_FAULT_RD) begin
                rd = {8'h00, core_reg.fault_reg};
              end
            end
          endcase
          if (cmd[7]) begin
            core_next.tx = is32 ? {cmd, rd, 8'h00} : {8'h00, rd, 8'h00};
          end else begin
            core_next.tx = is32 ? word : '0;
          end
        end
      end
      core_next.sdo = core_next.tx[WORD_W-1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  assign sdo = core_reg.sdo;
  assign fault_o = core_reg.fault_o;
  assign fault_oe_n = core_reg.fault_oe_n;
  assign cmd_valid = core_reg.cmd_valid;
  assign cmd_code = core_reg.cmd_code;
  assign cmd_chan = core_reg.cmd_chan;
  assign cmd_data = core_reg.cmd_data;

endmodule

// [verif/dacsp_host.sv]
`timescale 1ns/1ps
module dacsp_host (
  output logic link_sclk,
  output logic select_and_load_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    link_sclk = 1'b0;
    select_and_load_n = 1'b1;
    sdi = 1'b0;
  end
  // one frame msb first, collecting the reply on rising clock
  task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0000_0000;
    select_and_load_n = 1'b0;
    #62.5;
    // clock count is exactly n; chained use would pass multiples of 32
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #62.5 link_sclk = 1'b1;
      r = {r[30:0], sdo};
      #62.5 link_sclk = 1'b0;
    end
    sdi = ~sdi;
    #62.5 select_and_load_n = 1'b1;
    #200;
  endtask
endmodule

// [verif/dacsp_port_checker.sv]
`timescale 1ns/1ps
module dacsp_port_checker
  import dacsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic select_and_load_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic fault_o,
  input wire logic fault_oe_n,
  input wire logic cmd_valid,
  input wire dacsp_pkg::dacsp_byte_t cmd_code,
  input wire logic [3:0] cmd_chan,
  input wire dacsp_pkg::dacsp_half_t cmd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_valid_one_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse longer than one cycle");
  a_valid_after_rise: assert property (cmd_valid |-> $past(select_and_load_n, 2))
    else $error("command ran while the frame was open");
  a_chan_low_nibble: assert property (cmd_valid |-> cmd_chan == cmd_code[3:0])
    else $error("channel is not the low nibble");
  a_cmd_held: assert property (!cmd_valid |-> $stable({cmd_code, cmd_chan, cmd_data}))
    else $error("command outputs moved without a frame");
  a_fault_data_low: assert property (fault_o == 1'b0)
    else $error("error pin data not low");
  a_fault_set_end: assert property ($fell(fault_oe_n) |-> select_and_load_n)
    else $error("error pin set inside a frame");
  a_fault_release: assert property ($rose(fault_oe_n) |-> $past(select_and_load_n, 2))
    else $error("error pin released inside a frame");
  a_fault_no_exec: assert property ($fell(fault_oe_n) |-> !cmd_valid)
    else $error("bad frame was executed");
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import dacsp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_sclk, select_and_load_n, sdi, sdo, fault_o, fault_oe_n, cmd_valid;
  dacsp_byte_t cmd_code;
  logic [3:0] cmd_chan;
  dacsp_half_t cmd_data;
  logic [31:0] r;
  int err_total = 0;
  int tests_run = 0;
  int nv = 0;
  int cyc = 0;
  int v0;
  dacsp_port uut (.clk(clk), .rst(rst), .link_sclk(link_sclk),
    .select_and_load_n(select_and_load_n), .sdi(sdi), .sdo(sdo), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_chan(cmd_chan), .cmd_data(cmd_data));
  dacsp_host host (.link_sclk(link_sclk), .select_and_load_n(select_and_load_n),
    .sdi(sdi), .sdo(sdo));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) nv <= nv + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk({cmd_code, cmd_data}, 32'h0000_0000);
    chk(fault_oe_n, 1'b1);
    host.frame(32'h9500_0000, 32, r);
    host.frame(32'h8500_0000, 32, r);
    chk(r, 32'h9500_0000);
    host.frame(32'hFF00_0000, 32, r);
    chk(r, 32'h8500_0000);
  endtask
  task automatic t_write();
    v0 = nv;
    host.frame(32'h0312_3400, 32, r);
    chk(nv - v0, 1);
    chk({cmd_code, cmd_chan, cmd_data}, 32'h0033_1234);
    host.frame(32'h8300_0000, 32, r);
    chk(r, 32'h0312_3400);
    host.frame(32'hFF00_0000, 32, r);
    chk(r, 32'h8312_3400);
  endtask
  task automatic t_short();
    host.frame(32'h0005_A5A5, 24, r);
    chk({cmd_code, cmd_data}, 32'h0005_A5A5);
    host.frame(32'h8500_0000, 32, r);
    chk(r, 32'h0000_0000);
    host.frame(32'h0085_0000, 24, r);
    chk(r, 32'h0085_A5A5);
    host.frame(32'hFF00_0000, 32, r);
    chk(r, 32'h00A5_A500);
  endtask
  task automatic t_bad();
    v0 = nv;
    host.frame(32'h0005_FFFF, 20, r);
    chk(nv - v0, 0);
    chk(fault_oe_n, 1'b0);
    chk(cmd_code, 8'hFF);
    host.frame(32'h8500_0000, 32, r);
    chk(r, 32'h0000_0000);
    chk(fault_oe_n, 1'b1);
    host.frame(32'hFF00_0000, 32, r);
    chk(r, 32'h85A5_A500);
  endtask
  task automatic t_crc();
    host.frame(32'h7000_0100, 32, r);
    host.frame(32'h0006_1234, 24, r);
    chk({fault_oe_n, cmd_code, cmd_data}, 32'h0106_1234);
    // all-zero payload has a zero check code, so a set low bit is a mismatch
    v0 = nv;
    host.frame(32'h0000_0001, 32, r);
    chk(nv - v0, 0);
    chk(fault_oe_n, 1'b0);
    host.frame(32'h0000_0000, 32, r);
    chk(nv - v0, 1);
    chk(fault_oe_n, 1'b1);
    host.frame(32'h7000_003F, 32, r);
    chk({fault_oe_n, cmd_code}, 9'h170);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_reset();
    t_write();
    t_short();
    t_bad();
    t_crc();
    give_verdict();
  end
endmodule
bind dacsp_port dacsp_port_checker chk_i (.clk(clk), .rst(rst), .link_sclk(link_sclk),
  .select_and_load_n(select_and_load_n), .sdi(sdi), .sdo(sdo), .fault_o(fault_o),
  .fault_oe_n(fault_oe_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_chan(cmd_chan), .cmd_data(cmd_data));
